// >>> rtl/uft_regs.vh
`ifndef UFT_REGS_VH
`define UFT_REGS_VH
// register byte offsets
`define UFT_OFS_DATA     8'h00
`define UFT_OFS_CTRL     8'h04
`define UFT_OFS_FMT      8'h08
`define UFT_OFS_STAT     8'h0c
`define UFT_OFS_BAUD     8'h10
// control register bit positions
`define UFT_CTRL_TXON    0
`define UFT_CTRL_NINTH   1
`define UFT_CTRL_DBL     2
`define UFT_CTRL_SYNC    3
`define UFT_CTRL_MSTR    4
// format register field positions
`define UFT_FMT_SIZE_LO  0
`define UFT_FMT_SIZE_HI  2
`define UFT_FMT_PAR_LO   4
`define UFT_FMT_PAR_HI   5
`define UFT_FMT_STOP     6
// status register bit positions
`define UFT_STAT_EMPTY   0
`define UFT_STAT_DONE    1
`define UFT_STAT_FERR    2
`define UFT_STAT_BUSY    3
// character size and parity codes
`define UFT_SIZE_5       3'h0
`define UFT_SIZE_6       3'h1
`define UFT_SIZE_7       3'h2
`define UFT_SIZE_8       3'h3
`define UFT_SIZE_9       3'h7
`define UFT_PAR_EVEN     2'h2
`define UFT_PAR_ODD      2'h3
// reset values
`define UFT_RST_CTRL     5'h00
`define UFT_RST_FMT      7'h03
`define UFT_RST_BAUD     12'h000
// prescaler terminal counts: divide by 16, 8, 2
`define UFT_PRE_NORM     4'hf
`define UFT_PRE_DBL      4'h7
`define UFT_PRE_SYNC     4'h1
// receiver samples per bit
`define UFT_OS_NORM      5'h10
`define UFT_OS_DBL       5'h08
`define UFT_OS_SYNC      5'h01
`endif

// >>> rtl/uft_baud.v
`timescale 1ns/1ps
`include "uft_regs.vh"
module uft_baud #(
    parameter DIVW = 12
) (
    // clock and reset
    input  wire            mclk_i,
    input  wire            rstn_i,
    // rate selection
    input  wire [DIVW-1:0] divisor_i,
    input  wire            div_load_i,
    input  wire            double_rate_i,
    input  wire            sync_mode_i,
    input  wire            sync_master_i,
    // transfer clock pin
    input  wire            xck_i,
    output reg             xck_o,
    // rate enables
    output reg             base_tick_o,
    output reg             bit_en_o
);
    reg [DIVW-1:0] cnt_r;      // baud down-counter
    reg [3:0]      pre_r;      // bit prescaler
    reg            xs1_r;      // synchroniser stage one
    reg            xs2_r;      // synchroniser stage two
    reg            xs3_r;      // edge detector history
    wire [3:0]     pre_top = sync_mode_i ? `UFT_PRE_SYNC :
                             (double_rate_i ? `UFT_PRE_DBL : `UFT_PRE_NORM);
    wire           slave   = sync_mode_i & ~sync_master_i;

    // divisor counter, reloaded at zero or on a divisor write
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_r       <= {DIVW{1'b0}};
            base_tick_o <= 1'b0;
        end else begin
            base_tick_o <= (cnt_r == {DIVW{1'b0}}) & ~div_load_i;
            if (div_load_i || cnt_r == {DIVW{1'b0}}) begin
                cnt_r <= divisor_i;
            end else begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

    // bit enable from prescaler, or from external clock rising edge
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pre_r    <= 4'h0;
            bit_en_o <= 1'b0;
            xck_o    <= 1'b0;
            xs1_r    <= 1'b0;
            xs2_r    <= 1'b0;
            xs3_r    <= 1'b0;
        end else begin
            xs1_r <= xck_i;
            xs2_r <= xs1_r;
            xs3_r <= xs2_r;
            if (div_load_i) begin
                pre_r <= 4'h0;
            end else if (base_tick_o) begin
                pre_r <= (pre_r >= pre_top) ? 4'h0 : pre_r + 1'b1;
            end
            if (slave) begin
                // two clock delay through sync, edge detect on stage two
                bit_en_o <= xs2_r & ~xs3_r;
            end else begin
                bit_en_o <= base_tick_o & (pre_r == 4'h0) & ~div_load_i;
            end
            // master clock rises with each bit enable, one cycle before txd_r changes
            if (!(sync_mode_i & sync_master_i)) begin
                xck_o <= 1'b0;
            end else if (base_tick_o) begin
                xck_o <= (pre_r == 4'h0);
            end
        end
    end
endmodule

// >>> rtl/uft_rxchk.v
`timescale 1ns/1ps
module uft_rxchk (
    // clock and reset
    input  wire       mclk_i,
    input  wire       rstn_i,
    // shared format and rate
    input  wire       samp_en_i,
    input  wire [4:0] os_i,
    input  wire [3:0] nbits_i,
    input  wire       par_en_i,
    // line
    input  wire       rxd_i,
    // result
    output reg        ferr_o
);
    localparam R_IDLE  = 2'h0;
    localparam R_START = 2'h1;
    localparam R_BITS  = 2'h2;
    localparam R_STOP  = 2'h3;
    reg [1:0]  st_r;       // framing state
    reg [4:0]  cnt_r;      // samples to next bit centre
    reg [3:0]  bits_r;     // bits taken so far
    wire [3:0] last = nbits_i + {3'h0, par_en_i} - 4'h1;

    // frame tracker; only the first stop bit is looked at
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r   <= R_IDLE;
            cnt_r  <= 5'h00;
            bits_r <= 4'h0;
            ferr_o <= 1'b0;
        end else begin
            ferr_o <= 1'b0;
            if (samp_en_i) begin
                case (st_r)
                    R_IDLE: begin
                        if (!rxd_i) begin
                            cnt_r  <= os_i >> 1;
                            bits_r <= 4'h0;
                            st_r   <= (os_i == 5'h01) ? R_BITS : R_START;
                        end
                    end
                    R_START: begin
                        if (cnt_r != 5'h00) begin
                            cnt_r <= cnt_r - 1'b1;
                        end else if (rxd_i) begin
                            st_r <= R_IDLE;   // glitch, not a start
                        end else begin
                            cnt_r <= os_i - 1'b1;
                            st_r  <= R_BITS;
                        end
                    end
                    R_BITS: begin
                        if (cnt_r != 5'h00) begin
                            cnt_r <= cnt_r - 1'b1;
                        end else begin
                            cnt_r <= os_i - 1'b1;
                            if (bits_r == last) begin
                                st_r <= R_STOP;
                            end else begin
                                bits_r <= bits_r + 1'b1;
                            end
                        end
                    end
                    R_STOP: begin
                        if (cnt_r != 5'h00) begin
                            cnt_r <= cnt_r - 1'b1;
                        end else begin
                            ferr_o <= ~rxd_i;
                            st_r   <= R_IDLE;   // second stop ignored
                        end
                    end
                    default: st_r <= R_IDLE;
                endcase
            end
        end
    end
endmodule

// >>> rtl/uft_top.v
`timescale 1ns/1ps
`include "uft_regs.vh"
module uft_top #(
    parameter AW   = 8,
    parameter DW   = 16,
    parameter DIVW = 12
) (
    // clock and reset
    input  wire          mclk_i,
    input  wire          rstn_i,
    // register port
    input  wire [AW-1:0] addr_i,
    input  wire [DW-1:0] wdata_i,
    input  wire          wr_i,
    input  wire          rd_i,
    output reg  [DW-1:0] rdata_o,
    // serial line
    output reg           serial_out_pin_o,
    output reg           serial_out_pin_oe_n_o,
    input  wire          rxd_i,
    // transfer clock pin
    input  wire          sync_clock_pin_i,
    output wire          sync_clock_pin_o,
    output reg           sync_clock_pin_oe_n_o,
    // status flags
    output reg           tx_buffer_empty_flag_o,
    output reg           tx_done_flag_o
);
    // transmit states
    localparam T_IDLE  = 3'h0;
    localparam T_WAIT  = 3'h1;
    localparam T_START = 3'h2;
    localparam T_DATA  = 3'h3;
    localparam T_PAR   = 3'h4;
    localparam T_STOP1 = 3'h5;
    localparam T_STOP2 = 3'h6;

    // address match against one register offset
    function hit;
        input [AW-1:0] a;
        input [AW-1:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    // data bit count for a size code
    function [3:0] nbits_of;
        input [2:0] code;
        begin
            case (code)
                `UFT_SIZE_5: nbits_of = 4'h5;
                `UFT_SIZE_6: nbits_of = 4'h6;
                `UFT_SIZE_7: nbits_of = 4'h7;
                `UFT_SIZE_8: nbits_of = 4'h8;
                `UFT_SIZE_9: nbits_of = 4'h9;
                default:     nbits_of = 4'h8;   // reserved codes act as 8
            endcase
        end
    endfunction

    // software visible state
    reg [4:0]      ctrl_r;        // enable, ninth bit, rate and mode
    reg [6:0]      fmt_r;         // size, parity, stop count
    reg [DIVW-1:0] baud_r;        // baud divisor
    reg [8:0]      buf_r;         // single entry transmit buffer
    reg            buf_full_r;    // buffer holds a pending character
    reg            done_r;        // sticky transmit done
    reg            ferr_r;        // sticky frame error
    // transmit engine
    reg [2:0]      st_r;          // frame state
    reg [8:0]      shf_r;         // transmit shift register
    reg [3:0]      cnt_r;         // data bits sent so far
    reg            par_r;         // parity of loaded character
    reg            txd_r;         // line level being sent

    // decoded fields of the shared format
    wire [2:0] char_size_sel   = fmt_r[`UFT_FMT_SIZE_HI:`UFT_FMT_SIZE_LO];
    wire [1:0] parity_mode_sel = fmt_r[`UFT_FMT_PAR_HI:`UFT_FMT_PAR_LO];
    wire       stop_count_sel  = fmt_r[`UFT_FMT_STOP];
    wire       transmitter_on  = ctrl_r[`UFT_CTRL_TXON];
    wire       ninth_tx_bit    = ctrl_r[`UFT_CTRL_NINTH];
    wire       double_rate_sel = ctrl_r[`UFT_CTRL_DBL];
    wire       sync_mode_sel   = ctrl_r[`UFT_CTRL_SYNC];
    wire       sync_master_sel = ctrl_r[`UFT_CTRL_MSTR];
    // upper code bit set means parity on, low bit picks odd
    wire       par_en  = parity_mode_sel[1];
    wire       par_odd = parity_mode_sel == `UFT_PAR_ODD;
    wire [3:0] nbits   = nbits_of(char_size_sel);

    // bus strobes decoded once
    wire wr_data = wr_i & hit(addr_i, `UFT_OFS_DATA);
    wire wr_ctrl = wr_i & hit(addr_i, `UFT_OFS_CTRL);
    wire wr_fmt  = wr_i & hit(addr_i, `UFT_OFS_FMT);
    wire wr_stat = wr_i & hit(addr_i, `UFT_OFS_STAT);
    wire wr_baud = wr_i & hit(addr_i, `UFT_OFS_BAUD);

    // rate enables
    wire base_tick;
    wire bit_en;
    wire ferr_pulse;

    // divisor plus one, then 16, 8 or 2 per bit
    uft_baud #(
        .DIVW          (DIVW)
    ) u_baud (
        .mclk_i        (mclk_i),
        .rstn_i        (rstn_i),
        .divisor_i     (baud_r),
        .div_load_i    (wr_baud),
        .double_rate_i (double_rate_sel),
        .sync_mode_i   (sync_mode_sel),
        .sync_master_i (sync_master_sel),
        .xck_i         (sync_clock_pin_i),
        .xck_o         (sync_clock_pin_o),
        .base_tick_o   (base_tick),
        .bit_en_o      (bit_en)
    );

    // receiver framing sees the very same format fields
    wire [4:0] rx_os = sync_mode_sel ? `UFT_OS_SYNC :
                       (double_rate_sel ? `UFT_OS_DBL : `UFT_OS_NORM);
    uft_rxchk u_rxchk (
        .mclk_i    (mclk_i),
        .rstn_i    (rstn_i),
        .samp_en_i (sync_mode_sel ? bit_en : base_tick),
        .os_i      (rx_os),
        .nbits_i   (nbits),
        .par_en_i  (par_en),
        .rxd_i     (rxd_i),
        .ferr_o    (ferr_pulse)
    );

    // masked character and its parity, formed at load time
    reg [8:0] load_data;
    reg       load_par;
    integer   i;
    always @* begin
        load_data = 9'h000;
        for (i = 0; i < 9; i = i + 1) begin
            if (i < nbits) begin
                load_data[i] = buf_r[i];
            end
        end
        load_par = (^load_data) ^ par_odd;
    end

    // engine events
    wire last_stop = bit_en &
                     ((st_r == T_STOP1 && !stop_count_sel) ||
                      st_r == T_STOP2);
    wire idle_load = (st_r == T_IDLE) & buf_full_r;
    wire chain     = last_stop & buf_full_r;
    wire load      = idle_load | chain;
    wire set_done  = last_stop & ~buf_full_r;
    wire active    = (st_r != T_IDLE);

    // control registers; format is not latched per frame, so a
    // change in flight reshapes the running frame
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_r <= `UFT_RST_CTRL;
            fmt_r  <= `UFT_RST_FMT;
            baud_r <= `UFT_RST_BAUD;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= wdata_i[4:0];
            end
            if (wr_fmt) begin
                fmt_r <= wdata_i[6:0];
            end
            if (wr_baud) begin
                baud_r <= wdata_i[DIVW-1:0];
            end
        end
    end

    // transmit buffer; ninth bit taken from control at the write
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            buf_r      <= 9'h000;
            buf_full_r <= 1'b0;
        end else begin
            if (wr_data) begin
                buf_r      <= {ninth_tx_bit, wdata_i[7:0]};
                buf_full_r <= 1'b1;      // write beats same-cycle load
            end else if (load) begin
                buf_full_r <= 1'b0;
            end
        end
    end

    // sticky flags; a set in the clearing cycle wins
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            done_r <= 1'b0;
            ferr_r <= 1'b0;
        end else begin
            if (set_done) begin
                done_r <= 1'b1;
            end else if (wr_stat && wdata_i[`UFT_STAT_DONE]) begin
                done_r <= 1'b0;
            end
            if (ferr_pulse) begin
                ferr_r <= 1'b1;
            end else if (wr_stat && wdata_i[`UFT_STAT_FERR]) begin
                ferr_r <= 1'b0;
            end
        end
    end

    // frame engine; each bit_en ends one bit and starts the next
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r  <= T_IDLE;
            shf_r <= 9'h000;
            cnt_r <= 4'h0;
            par_r <= 1'b0;
            txd_r <= 1'b1;
        end else begin
            if (idle_load) begin
                // wait for a bit boundary so the start bit is whole
                shf_r <= load_data;
                par_r <= load_par;
                st_r  <= T_WAIT;
            end else if (bit_en) begin
                case (st_r)
                    T_WAIT: begin
                        txd_r <= 1'b0;
                        st_r  <= T_START;
                    end
                    T_START: begin
                        txd_r <= shf_r[0];
                        shf_r <= shf_r >> 1;
                        cnt_r <= 4'h1;
                        st_r  <= T_DATA;
                    end
                    T_DATA: begin
                        if (cnt_r >= nbits) begin
                            if (par_en) begin
                                txd_r <= par_r;
                                st_r  <= T_PAR;
                            end else begin
                                txd_r <= 1'b1;
                                st_r  <= T_STOP1;
                            end
                        end else begin
                            txd_r <= shf_r[0];
                            shf_r <= shf_r >> 1;
                            cnt_r <= cnt_r + 1'b1;
                        end
                    end
                    T_PAR: begin
                        txd_r <= 1'b1;
                        st_r  <= T_STOP1;
                    end
                    T_STOP1, T_STOP2: begin
                        if (st_r == T_STOP1 && stop_count_sel) begin
                            st_r <= T_STOP2;
                        end else if (chain) begin
                            // next start bit follows with no gap
                            shf_r <= load_data;
                            par_r <= load_par;
                            txd_r <= 1'b0;
                            st_r  <= T_START;
                        end else begin
                            txd_r <= 1'b1;
                            st_r  <= T_IDLE;
                        end
                    end
                    default: begin
                        txd_r <= 1'b1;
                        st_r  <= T_IDLE;
                    end
                endcase
            end
        end
    end

    // pin ownership; disable waits until nothing is pending
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            serial_out_pin_o       <= 1'b1;
            serial_out_pin_oe_n_o  <= 1'b1;
            sync_clock_pin_oe_n_o  <= 1'b1;
            tx_buffer_empty_flag_o <= 1'b1;
            tx_done_flag_o         <= 1'b0;
        end else begin
            serial_out_pin_o       <= txd_r | ~active;
            serial_out_pin_oe_n_o  <= ~(transmitter_on | active |
                                        buf_full_r);
            sync_clock_pin_oe_n_o  <= ~(sync_mode_sel &
                                        sync_master_sel);
            tx_buffer_empty_flag_o <= ~buf_full_r;
            tx_done_flag_o         <= done_r;
        end
    end

    // read port; data valid only in the cycle after the strobe
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= {DW{1'b0}};
        end else if (rd_i) begin
            rdata_o <= {DW{1'b0}};
            if (hit(addr_i, `UFT_OFS_CTRL)) begin
                rdata_o[4:0] <= ctrl_r;
            end else if (hit(addr_i, `UFT_OFS_FMT)) begin
                rdata_o[6:0] <= fmt_r;
            end else if (hit(addr_i, `UFT_OFS_STAT)) begin
                rdata_o[`UFT_STAT_EMPTY] <= ~buf_full_r;
                rdata_o[`UFT_STAT_DONE]  <= done_r;
                rdata_o[`UFT_STAT_FERR]  <= ferr_r;
                rdata_o[`UFT_STAT_BUSY]  <= active;
            end else if (hit(addr_i, `UFT_OFS_BAUD)) begin
                rdata_o[DIVW-1:0] <= baud_r;
            end
        end else begin
            rdata_o <= {DW{1'b0}};
        end
    end
endmodule

// >>> bench/uft_props.sv
`timescale 1ns/1ps
`include "uft_regs.vh"
module uft_props #(
    parameter AW   = 8,
    parameter DW   = 16,
    parameter DIVW = 12
) (
    // clock, reset and register port
    input wire          mclk_i,
    input wire          rstn_i,
    input wire [AW-1:0] addr_i,
    input wire [DW-1:0] wdata_i,
    input wire          wr_i,
    input wire          rd_i,
    input wire [DW-1:0] rdata_o,
    // pins and flags
    input wire          serial_out_pin_o,
    input wire          serial_out_pin_oe_n_o,
    input wire          rxd_i,
    input wire          sync_clock_pin_i,
    input wire          sync_clock_pin_o,
    input wire          sync_clock_pin_oe_n_o,
    input wire          tx_buffer_empty_flag_o,
    input wire          tx_done_flag_o
);
    reg wrd_q_r;  // data write one cycle ago
    reg wrd_qq_r; // data write two cycles ago
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    // flag lags the buffer by a cycle, so keep two cycles of history
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wrd_q_r  <= 1'b0;
            wrd_qq_r <= 1'b0;
        end else begin
            wrd_q_r  <= wr_i && (addr_i == `UFT_OFS_DATA);
            wrd_qq_r <= wrd_q_r;
        end
    end
    sequence s_data_wr; wr_i && (addr_i == `UFT_OFS_DATA); endsequence
    sequence s_buf_full; ##[1:2] !tx_buffer_empty_flag_o; endsequence
    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == {DW{1'b0}})
        else $error("read data not zero outside read cycle");
    a_empty_clears: assert property (s_data_wr |-> s_buf_full)
        else $error("empty flag stayed set after data write");
    a_empty_cause: assert property ($fell(tx_buffer_empty_flag_o)
        |-> wrd_q_r || wrd_qq_r) else $error("empty flag fell unprompted");
    a_bit_hold: assert property ($fell(serial_out_pin_o)
        && sync_clock_pin_oe_n_o |-> !serial_out_pin_o [*4])
        else $error("low bit shorter than a bit period");
    a_low_owned: assert property (!serial_out_pin_o
        |-> !serial_out_pin_oe_n_o) else $error("line low on released pin");
    a_done_cause: assert property ($rose(tx_done_flag_o)
        |-> tx_buffer_empty_flag_o && serial_out_pin_o)
        else $error("done flag rose with data pending or line low");
    a_stop_high: assert property ($rose(tx_done_flag_o)
        |-> $past(serial_out_pin_o, 4)) else $error("stop bit not high");
    a_xck_quiet: assert property (sync_clock_pin_oe_n_o
        |-> !sync_clock_pin_o) else $error("transfer clock out when released");
endmodule

// >>> bench/uft_peer.sv
`timescale 1ns/1ps
// remote receiver: samples the line at bit centres
module uft_peer #(
    parameter BITC = 16 // clocks per bit, divisor 0 normal rate
) (
    // clock and line
    input  wire        mclk_i,
    input  wire        line_i,
    // echo and capture
    output wire        rxd_o,
    output reg  [22:0] frame_o,
    output reg  [7:0]  cnt_o
);
    integer i; // bit index after the start bit
    // echo the line so the local stop check sees real frames
    assign rxd_o = line_i;
    // fixed window catches idle or a following frame
    initial begin
        frame_o = 23'h000000;
        cnt_o   = 8'h00;
        forever begin
            @(negedge line_i); // start bit is low
            repeat (BITC / 2) @(posedge mclk_i);
            for (i = 0; i < 23; i = i + 1) begin
                repeat (BITC) @(posedge mclk_i);
                frame_o[i] = line_i; // lsb first
            end
            cnt_o = cnt_o + 8'h01;
        end
    end
endmodule

// >>> bench/testbench.sv
`timescale 1ns/1ps
`include "uft_regs.vh"
module testbench;
    reg         mclk_i  = 1'b0;     // 200 MHz clock
    reg         rstn_i  = 1'b0;     // reset, active low
    reg  [7:0]  addr_i  = 8'h00;    // register address
    reg  [15:0] wdata_i = 16'h0000; // write data
    reg         wr_i    = 1'b0;     // write strobe
    reg         rd_i    = 1'b0;     // read strobe
    wire [15:0] rdata_o;            // read data
    wire        sout, oe_n, rxd, xck, xck_oe_n, empty, done;
    wire [22:0] frame;              // peer capture
    wire [7:0]  fcnt;               // peer frame count
    integer     err_count = 0;
    integer     checks    = 0;
    reg  [15:0] rv;                 // last read value
    reg  [3:0]  xdiv    = 4'h0;     // slave transfer clock divider
    reg         xrun    = 1'b0;     // slave clock runs, else stands
    reg  [15:0] mode    = 16'h0000; // extra control bits per test
    always #2.5 mclk_i = ~mclk_i;
    // external clock for sync slave, one bit per 16 clocks like the peer
    always @(posedge mclk_i) xdiv <= xdiv + {3'h0, xrun};
    uft_top uft_top_i (.mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .serial_out_pin_o(sout), .serial_out_pin_oe_n_o(oe_n),
        .rxd_i(rxd), .sync_clock_pin_i(xdiv[3]), .sync_clock_pin_o(xck),
        .sync_clock_pin_oe_n_o(xck_oe_n), .tx_buffer_empty_flag_o(empty),
        .tx_done_flag_o(done));
    uft_peer uft_peer_i (.mclk_i(mclk_i), .line_i(sout), .rxd_o(rxd),
        .frame_o(frame), .cnt_o(fcnt));
    task chk(input string nm, input [22:0] seen, input [22:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("[ERR] %0s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // one write cycle, strobe dropped after the taking edge
    task wr(input [7:0] a, input [15:0] d);
        @(posedge mclk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge mclk_i);
        wr_i    <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task rd(input [7:0] a, output [15:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge mclk_i);
        rd_i   <= 1'b0;
        #1 d = rdata_o;
    endtask
    // bounded wait for the peer to finish a capture
    task wait_frame(input [7:0] c0);
        integer k;
        for (k = 0; k < 3000 && fcnt == c0; k = k + 1) @(posedge mclk_i);
        if (fcnt == c0) begin
            chk("frame timeout", 23'h1, 23'h0);
            end_of_test;
        end
    endtask
    // expected line after the start bit, idle ones beyond the frame
    function [22:0] efr(input [6:0] f, input [8:0] d);
        integer i, n;
        reg     p;
        efr = {23{1'b1}}; // stops and idle high
        n = (f[2:0] == 3'h7) ? 9 : f[2:0] + 5;
        p = f[4]; // odd code starts inverted
        for (i = 0; i < n; i = i + 1) begin
            efr[i] = d[i];
            p = p ^ d[i];
        end
        if (f[5]) efr[n] = p; // parity after last data bit
    endfunction
    task t_regs;
        rd(`UFT_OFS_FMT, rv);
        chk("fmt reset", rv, 23'h0003);
        rd(`UFT_OFS_STAT, rv);
        chk("stat reset", rv, 23'h0001);
        rd(8'h14, rv);
        chk("unmapped", rv, 23'h0000);
        wr(`UFT_OFS_CTRL, 16'h0019); // sync master, idle line
        repeat (3) @(posedge mclk_i);
        #1 chk("xck owned", xck_oe_n, 23'h0);
        rv[0] = xck;
        @(posedge mclk_i);
        #1 chk("xck runs", xck ^ rv[0], 23'h1);
        wr(`UFT_OFS_CTRL, 16'h0001);
        rd(`UFT_OFS_CTRL, rv);
        chk("ctrl", rv, 23'h0001);
        chk("pin owned", oe_n, 23'h0);
        chk("xck idle", xck, 23'h0);
        $display("register test done");
    endtask
    task t_frame(input [6:0] f, input [8:0] d);
        reg [7:0] c0;
        wr(`UFT_OFS_FMT, {9'h000, f});
        wr(`UFT_OFS_CTRL, {14'h0000, d[8], 1'b1} | mode);
        wr(`UFT_OFS_STAT, 16'h0002); // clear done before data
        c0 = fcnt;
        wr(`UFT_OFS_DATA, {8'hff, d[7:0]});
        chk("done clear", done, 23'h0);
        wait_frame(c0);
        chk("frame", frame, efr(f, d));
        chk("done", done, 23'h1);
        rd(`UFT_OFS_STAT, rv);
        chk("stat after", rv, 23'h0003);
        $display("frame test %h done", f);
    endtask
    task t_b2b;
        reg [7:0]  c0;
        reg [22:0] e;
        reg [22:0] e2;
        integer    k;
        wr(`UFT_OFS_FMT, 16'h0043); // eight bits, two stops
        c0 = fcnt;
        wr(`UFT_OFS_DATA, 16'h00c5);
        repeat (4) @(posedge mclk_i);
        for (k = 0; k < 40 && empty !== 1'b1; k = k + 1) @(posedge mclk_i);
        if (empty !== 1'b1) begin
            chk("empty timeout", 23'h1, 23'h0);
            end_of_test;
        end
        wr(`UFT_OFS_DATA, 16'h003a); // polled empty first
        repeat (2) @(posedge mclk_i);
        #1 chk("buffer held", empty, 23'h0);
        wait_frame(c0);
        e  = efr(7'h43, 9'h0c5);
        e2 = efr(7'h43, 9'h03a);
        e[10]    = 1'b0; // no gap after second stop
        e[22:11] = e2[11:0];
        chk("back to back", frame, e);
        $display("back to back test done");
    endtask
    // external clock paces each bit in sync slave mode
    task t_slave;
        mode <= 16'h0008; // sync mode, clock taken from the pin
        xrun <= 1'b1;
        t_frame(7'h03, 9'h05a);
        xrun <= 1'b0;
    endtask
    initial begin
        repeat (8) @(posedge mclk_i);
        rstn_i <= 1'b1;
        t_regs;
        t_frame(7'h00, 9'h0ea);
        t_frame(7'h21, 9'h02d);
        t_frame(7'h32, 9'h055);
        t_frame(7'h13, 9'h0a3);
        t_frame(7'h37, 9'h10f);
        t_b2b;
        t_slave;
        end_of_test;
    end
endmodule
bind uft_top uft_props #(.AW(AW), .DW(DW), .DIVW(DIVW)) uft_props_i (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .serial_out_pin_o(serial_out_pin_o), .rxd_i(rxd_i),
    .serial_out_pin_oe_n_o(serial_out_pin_oe_n_o),
    .sync_clock_pin_i(sync_clock_pin_i), .sync_clock_pin_o(sync_clock_pin_o),
    .sync_clock_pin_oe_n_o(sync_clock_pin_oe_n_o),
    .tx_buffer_empty_flag_o(tx_buffer_empty_flag_o),
    .tx_done_flag_o(tx_done_flag_o));
